// ==== core/csrb_pkg.sv ====
// Shared constants and carrier types of the converter status/readback block
package csrb_pkg;

  // Channel count and data widths
  localparam int CSRB_CHANS = 4;
  localparam int CSRB_DATA_W = 28;
  localparam int CSRB_ERR_W = 6;
  localparam int CSRB_FIFO_DEPTH = 8;

  // Register offsets on the serial register port
  localparam logic [7:0] CSRB_ADDR_RESULT = 8'h00;
  localparam logic [7:0] CSRB_ADDR_STATUS = 8'h18;
  localparam logic [7:0] CSRB_ADDR_MASK = 8'h19;
  localparam logic [7:0] CSRB_ADDR_CONFIG = 8'h1a;
  localparam logic [7:0] CSRB_ADDR_SWRST = 8'h1c;

  // Status word layout
  localparam int CSRB_ST_ERRCH_LSB = 14;
  localparam int CSRB_ST_ERR_LSB = 8;
  localparam int CSRB_ST_DRDY_BIT = 6;
  localparam int CSRB_ST_UNREAD_LSB = 0;

  // Mask, configuration and soft reset fields
  localparam int CSRB_MASK_ERR_LSB = 8;
  localparam int CSRB_MASK_DRDY_BIT = 0;
  localparam int CSRB_CFG_SLEEP_BIT = 13;
  localparam int CSRB_CFG_IRQDIS_BIT = 7;
  localparam int CSRB_SWRST_BIT = 15;

  // Values after reset
  localparam logic [15:0] CSRB_CFG_RESET = 16'h2000;
  localparam logic [15:0] CSRB_MASK_RESET = 16'h0000;
  localparam logic [6:0] CSRB_I2C_ADDR_DEF = 7'h2b;

  // One finished conversion as it travels to the holding buffer
  typedef struct packed {
    logic last;
    logic [1:0] chan;
    logic [CSRB_ERR_W-1:0] err;
    logic [CSRB_DATA_W-1:0] data;
  } csrb_conv_s;

  localparam int CSRB_CONV_W = $bits(csrb_conv_s);

  // Serial register port states
  typedef enum logic [2:0] {
    CSRB_IDLE,
    CSRB_ADDR,
    CSRB_RX,
    CSRB_TX,
    CSRB_ACK_SLV,
    CSRB_ACK_MST
  } csrb_i2c_e;

endpackage

// ==== core/csrb_fifo.sv ====
// Small FIFO with registered read data, between conversion engine and buffer
`timescale 1ns/10ps
`default_nettype none

module csrb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // Pointer width; DEPTH must be a power of two so pointers wrap cleanly
  localparam int AW = $clog2(DEPTH);

  // Whole FIFO state, storage included
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic room;
    logic ov;
    logic [WIDTH-1:0] od;
  } csrb_fifo_s;

  csrb_fifo_s r_reg; // Registered state
  csrb_fifo_s r_next; // Next state
  logic push; // Word accepted this cycle
  logic load; // Head moves to output stage

  // Next-state logic
  always_comb
  begin
    r_next = r_reg;
    push = in_valid & r_reg.room;
    // Refill output stage when it is empty or being taken
    load = (r_reg.cnt != '0) & (~r_reg.ov | out_ready);
    if (push)
    begin
      r_next.mem[r_reg.wp] = in_data;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (load)
    begin
      r_next.od = r_reg.mem[r_reg.rp];
      r_next.rp = r_reg.rp + 1'b1;
      r_next.ov = 1'b1;
    end
    else if (out_ready)
    begin
      r_next.ov = 1'b0;
    end
    r_next.cnt = r_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    // Registered so the ready seen upstream comes from a flop
    r_next.room = (r_next.cnt != (AW+1)'(DEPTH));
  end

  // State register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r_reg <= '0;
      r_reg.room <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign in_ready = r_reg.room;
  assign out_valid = r_reg.ov;
  assign out_data = r_reg.od;

endmodule

`default_nettype wire

// ==== core/csrb_top.sv ====
// Status, interrupt and coherent result readback over the serial port
`timescale 1ns/10ps
`default_nettype none

module csrb_top
  import csrb_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = csrb_pkg::CSRB_I2C_ADDR_DEF
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic shutdown_pin,
  output logic irq_n_pin,
  input wire logic conv_valid,
  input wire csrb_pkg::csrb_conv_s conv_word,
  output logic conv_ready
);

  import csrb_pkg::*;

  // Whole block state in one record
  typedef struct packed {
    logic [2:0] scl_s; // Clock line sync, [2] is edge history
    logic [2:0] sda_s; // Data line sync, [2] is edge history
    logic [1:0] sd_s; // Shutdown pin sync
    csrb_i2c_e fsm; // Serial port state
    logic [2:0] bitn; // Bit within byte
    logic [7:0] sh; // Receive shifter
    logic rw; // Read transfer selected
    logic [1:0] rxph; // 0 pointer, 1 high byte, 2 low byte
    logic ack_ph; // Acknowledge bit being driven
    logic lo; // Low byte of word on the line
    logic [7:0] ptr; // Register pointer
    logic [7:0] wbyte; // High byte of a write
    logic [15:0] rword; // Word being shifted out
    logic sda_oe_n; // Low while pulling data low
    logic [15:0] cfg; // Configuration
    logic [15:0] mask; // Interrupt enables for errors and group end
    logic [CSRB_CHANS-1:0][CSRB_DATA_W-1:0] hold; // Internal results
    logic [CSRB_CHANS-1:0][15:0] lsbv; // Visible lower words
    logic [CSRB_CHANS-1:0] unread; // Unread result flags
    logic [CSRB_ERR_W-1:0] err; // Sticky error bits
    logic [1:0] errch; // Channel of last error
    logic drdy; // Group finished
    logic [15:0] shown; // Status word the host sees
    logic pend; // Interrupt pending
    logic irq_n; // Pin level
  } csrb_state_s;

  csrb_state_s r; // Registered state
  csrb_state_s n; // Next state

  csrb_conv_s fifo_word; // Head of the result FIFO
  logic fifo_valid; // Head is valid
  logic fifo_ready; // Buffer takes the head
  logic drain; // Head taken this cycle
  logic scl_rise; // Clock line rose
  logic scl_fall; // Clock line fell
  logic bus_start; // Start condition seen
  logic bus_stop; // Stop condition seen
  logic [7:0] rx_byte; // Byte completed at this rise
  logic [15:0] rd_word; // Value of the pointed register
  logic [15:0] wr_data; // Word being written
  logic [15:0] live; // Status as it stands now
  logic rd_load; // Register read happens now
  logic rd_status; // Status register read
  logic rd_msb; // Result upper word read
  logic [1:0] rd_ch; // Channel of that read
  logic wr_commit; // Register write happens now
  logic ev_irq; // Unmasked event this cycle
  logic sleep; // Sleep or shutdown level
  logic swrst; // Soft reset pulse

  // Pointer addresses a result upper word
  function automatic logic is_upper(input logic [7:0] p);
    return (p[7:3] == CSRB_ADDR_RESULT[7:3]) && !p[0];
  endfunction

  // Value returned for a register read
  function automatic logic [15:0] reg_read(input csrb_state_s s,
                                           input logic [7:0] p);
    logic [15:0] v;
    v = 16'h0000;
    if (p[7:3] == CSRB_ADDR_RESULT[7:3])
    begin
      // Upper word comes from the buffer, lower from the latched copy
      if (p[0])
        v = s.lsbv[p[2:1]];
      else
        v = {4'h0, s.hold[p[2:1]][CSRB_DATA_W-1:16]};
    end
    else
    begin
      case (p)
        CSRB_ADDR_STATUS: v = s.shown;
        CSRB_ADDR_MASK: v = s.mask;
        CSRB_ADDR_CONFIG: v = s.cfg;
        default: v = 16'h0000; // Unmapped reads as zero
      endcase
    end
    return v;
  endfunction

  // Result FIFO; buffer stalls while a byte is being shifted out
  csrb_fifo #(
    .WIDTH(CSRB_CONV_W),
    .DEPTH(CSRB_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .in_data(conv_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_word)
  );

  // Holding the buffer still during a transmit keeps the two bytes coherent
  assign fifo_ready = (r.fsm != CSRB_TX);

  // Next-state logic
  always_comb
  begin
    n = r;
    // Pin synchronisers; stage 0 feeds stage 1 only
    n.scl_s = {r.scl_s[1:0], scl_in};
    n.sda_s = {r.sda_s[1:0], sda_in};
    n.sd_s = {r.sd_s[0], shutdown_pin};
    scl_rise = r.scl_s[1] & ~r.scl_s[2];
    scl_fall = ~r.scl_s[1] & r.scl_s[2];
    bus_start = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[1] & r.sda_s[2];
    bus_stop = r.scl_s[1] & r.scl_s[2] & r.sda_s[1] & ~r.sda_s[2];
    rx_byte = {r.sh[6:0], r.sda_s[1]};
    wr_data = {r.wbyte, rx_byte};
    rd_word = reg_read(r, r.ptr);
    rd_load = 1'b0;
    wr_commit = 1'b0;

    // Serial register port
    case (r.fsm)
      CSRB_ADDR:
      begin
        if (scl_rise)
        begin
          n.sh = rx_byte;
          n.bitn = r.bitn + 3'd1;
          if (r.bitn == 3'd7)
          begin
            // Answer only our own address
            if (rx_byte[7:1] == DEV_ADDR)
            begin
              n.rw = rx_byte[0];
              n.rxph = 2'd0;
              n.ack_ph = 1'b0;
              n.fsm = CSRB_ACK_SLV;
            end
            else
            begin
              n.fsm = CSRB_IDLE;
            end
          end
        end
      end
      CSRB_RX:
      begin
        if (scl_rise)
        begin
          n.sh = rx_byte;
          n.bitn = r.bitn + 3'd1;
          if (r.bitn == 3'd7)
          begin
            // Pointer, then high byte, then low byte commits
            case (r.rxph)
              2'd0: n.ptr = rx_byte;
              2'd1: n.wbyte = rx_byte;
              default: wr_commit = 1'b1;
            endcase
            n.rxph = (r.rxph == 2'd1) ? 2'd2 : 2'd1;
            n.ack_ph = 1'b0;
            n.fsm = CSRB_ACK_SLV;
          end
        end
      end
      CSRB_ACK_SLV:
      begin
        if (scl_fall)
        begin
          n.bitn = 3'd0;
          if (!r.ack_ph)
          begin
            // Pull data low for the acknowledge bit
            n.sda_oe_n = 1'b0;
            n.ack_ph = 1'b1;
          end
          else if (r.rw)
          begin
            // Read: take the register now, drive its first bit
            rd_load = 1'b1;
            n.rword = rd_word;
            n.sda_oe_n = rd_word[15];
            n.lo = 1'b0;
            n.fsm = CSRB_TX;
          end
          else
          begin
            n.sda_oe_n = 1'b1;
            n.fsm = CSRB_RX;
          end
        end
      end
      CSRB_TX:
      begin
        if (scl_fall)
        begin
          n.rword = {r.rword[14:0], 1'b0};
          n.bitn = r.bitn + 3'd1;
          if (r.bitn == 3'd7)
          begin
            n.sda_oe_n = 1'b1; // Release for the host's acknowledge
            n.fsm = CSRB_ACK_MST;
          end
          else
          begin
            n.sda_oe_n = r.rword[14];
          end
        end
      end
      CSRB_ACK_MST:
      begin
        if (scl_rise && r.sda_s[1])
        begin
          n.fsm = CSRB_IDLE; // Host said no more
        end
        else if (scl_fall)
        begin
          n.bitn = 3'd0;
          n.fsm = CSRB_TX;
          if (r.lo)
          begin
            // Further word: the same register is read afresh
            rd_load = 1'b1;
            n.rword = rd_word;
            n.sda_oe_n = rd_word[15];
            n.lo = 1'b0;
          end
          else
          begin
            n.sda_oe_n = r.rword[15];
            n.lo = 1'b1;
          end
        end
      end
      default: ; // Idle waits for a start
    endcase
    // Start and stop override any transfer
    if (bus_start)
    begin
      n.fsm = CSRB_ADDR;
      n.bitn = 3'd0;
      n.sda_oe_n = 1'b1;
    end
    else if (bus_stop)
    begin
      n.fsm = CSRB_IDLE;
      n.sda_oe_n = 1'b1;
    end

    // Read side effects
    rd_status = rd_load & (r.ptr == CSRB_ADDR_STATUS);
    rd_msb = rd_load & is_upper(r.ptr);
    rd_ch = r.ptr[2:1];
    if (rd_msb)
    begin
      n.lsbv[rd_ch] = r.hold[rd_ch][15:0];
      n.unread[rd_ch] = 1'b0;
    end
    if (rd_status)
    begin
      n.err = '0;
      n.errch = 2'd0;
      n.drdy = 1'b0;
    end

    // New result into the buffer; set wins over a read clear
    drain = fifo_valid & fifo_ready;
    ev_irq = 1'b0;
    if (drain)
    begin
      n.hold[fifo_word.chan] = fifo_word.data;
      n.unread[fifo_word.chan] = 1'b1;
      n.err = n.err | fifo_word.err;
      if (|fifo_word.err)
        n.errch = fifo_word.chan;
      if (fifo_word.last)
        n.drdy = 1'b1;
      ev_irq = (|(fifo_word.err & r.mask[CSRB_MASK_ERR_LSB +: CSRB_ERR_W]))
             | (fifo_word.last & r.mask[CSRB_MASK_DRDY_BIT]);
    end

    // Register writes; read-only targets ignore them
    if (wr_commit)
    begin
      case (r.ptr)
        CSRB_ADDR_MASK: n.mask = wr_data;
        CSRB_ADDR_CONFIG: n.cfg = wr_data;
        default: ;
      endcase
    end
    swrst = wr_commit & (r.ptr == CSRB_ADDR_SWRST) & wr_data[CSRB_SWRST_BIT];
    sleep = r.cfg[CSRB_CFG_SLEEP_BIT] | r.sd_s[1];

    // Status view is frozen while any bit shows, until a clearing read
    live = 16'h0000;
    live[CSRB_ST_ERRCH_LSB +: 2] = n.errch;
    live[CSRB_ST_ERR_LSB +: CSRB_ERR_W] = n.err;
    live[CSRB_ST_DRDY_BIT] = n.drdy;
    live[CSRB_ST_UNREAD_LSB +: CSRB_CHANS] = n.unread;
    if (!(|r.shown) || rd_status || rd_msb)
      n.shown = live;

    // Pending interrupt; a new event beats the releasing read
    n.pend = (r.pend & ~(rd_status | rd_msb)) | ev_irq;
    if (sleep || swrst)
    begin
      // Sleep, shutdown and soft reset drop data and interrupts
      n.pend = 1'b0;
      n.hold = '0;
      n.lsbv = '0;
      n.unread = '0;
      n.err = '0;
      n.errch = 2'd0;
      n.drdy = 1'b0;
      n.shown = 16'h0000;
    end
    if (swrst)
    begin
      n.cfg = CSRB_CFG_RESET;
      n.mask = CSRB_MASK_RESET;
    end
    // Disabled pin rests high whatever is pending
    n.irq_n = ~(r.pend & ~r.cfg[CSRB_CFG_IRQDIS_BIT]);
  end

  // State register; power-on reset clears all but the clock and data sync stages, data enable, configuration and pin level
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r <= '0;
      r.scl_s <= 3'h7;
      r.sda_s <= 3'h7;
      r.sda_oe_n <= 1'b1;
      r.cfg <= CSRB_CFG_RESET;
      r.mask <= CSRB_MASK_RESET;
      r.irq_n <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // The line is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe_n = r.sda_oe_n;
  assign irq_n_pin = r.irq_n;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_mask_gate: assert property ($rose(r.pend) |-> $past(ev_irq))
    else $error("interrupt pending without an enabled event");
  a_pin_active: assert property (
    (r.pend && !r.cfg[CSRB_CFG_IRQDIS_BIT]) |=> !irq_n_pin)
    else $error("pending interrupt not shown on pin");
  a_pin_disabled: assert property (
    r.cfg[CSRB_CFG_IRQDIS_BIT] |=> irq_n_pin)
    else $error("disabled interrupt pin not high");
  a_status_freeze: assert property (
    ((|r.shown) && !rd_status && !rd_msb && !sleep && !swrst)
      |=> $stable(r.shown))
    else $error("frozen status changed");
  a_read_release: assert property (
    ((rd_status || rd_msb) && !ev_irq) |=> !r.pend ##1 irq_n_pin)
    else $error("read did not release interrupt");
  a_status_clear: assert property (
    (rd_status && !drain) |=> (r.err == '0 && r.errch == 2'd0))
    else $error("status read left error bits");
  a_sleep_clear: assert property (
    (sleep || swrst) |=> (!r.pend && r.hold == '0 && r.lsbv == '0))
    else $error("sleep or reset left data or interrupt");
  a_drain_store: assert property (
    (drain && !sleep && !swrst) |=>
      (r.hold[$past(fifo_word.chan)] == $past(fifo_word.data)
       && r.unread[$past(fifo_word.chan)]))
    else $error("conversion not stored or flagged");
  a_ready_irq: assert property (
    (drain && fifo_word.last && r.mask[CSRB_MASK_DRDY_BIT] && !sleep
     && !swrst && !r.cfg[CSRB_CFG_IRQDIS_BIT]) |=> ##1 !irq_n_pin)
    else $error("group end did not pull interrupt low");
  a_lsb_load: assert property (
    (rd_msb && !sleep && !swrst) |=>
      (r.lsbv[$past(rd_ch)] == $past(r.hold[rd_ch][15:0])))
    else $error("upper read did not load lower word");
  a_lsb_hold: assert property (
    (!rd_msb && !sleep && !swrst) |=> $stable(r.lsbv))
    else $error("lower word changed without upper read");

endmodule

`default_nettype wire

// ==== verification/csrb_host_model.sv ====
// Serial register host model facing the readback block's two-wire port
`timescale 1ns/10ps
`default_nettype none

module csrb_host_model #(
  parameter int Q_NS = 50
) (
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  // Both lines released at power-up; the pull-up holds them high
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // One bit: data moves mid-low, sampled mid-high, clock idles high after
  task automatic xbit(input logic b, output logic r);
    scl = 1'b0;
    #(Q_NS);
    sda_drv = b;
    #(Q_NS);
    scl = 1'b1;
    #(Q_NS);
    r = sda_line;
    #(Q_NS);
  endtask

  // Eight bits MSB first, then the acknowledge slot
  task automatic xbyte(input logic [7:0] d, input logic a_in,
                       output logic [7:0] q, output logic a_out);
    for (int i = 7; i >= 0; i--)
      xbit(d[i], q[i]);
    xbit(a_in, a_out);
  endtask

  // Start; a repeated start first lifts data while the clock is low
  task automatic start_cond(input logic rep);
    #7;
    if (rep)
    begin
      scl = 1'b0;
      #(Q_NS);
      sda_drv = 1'b1;
      #(Q_NS);
      scl = 1'b1;
      #(Q_NS);
    end
    sda_drv = 1'b0;
    #(Q_NS);
  endtask

  // Stop, then the clock stands still until the next frame
  task automatic stop_cond();
    scl = 1'b0;
    #(Q_NS);
    sda_drv = 1'b0;
    #(Q_NS);
    scl = 1'b1;
    #(Q_NS);
    sda_drv = 1'b1;
    #(2 * Q_NS);
  endtask

  // Word write, high byte first; ok when every byte was acknowledged
  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ptr,
                        input logic [15:0] val, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start_cond(1'b0);
    xbyte({dev, 1'b0}, 1'b1, q, a0);
    xbyte(ptr, 1'b1, q, a1);
    xbyte(val[15:8], 1'b1, q, a2);
    xbyte(val[7:0], 1'b1, q, a3);
    stop_cond();
    ok = !(a0 | a1 | a2 | a3);
  endtask

  // Word read: pointer, repeated start, two bytes, closing not-acknowledge
  task automatic rd_reg(input logic [6:0] dev, input logic [7:0] ptr,
                        output logic [15:0] val, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start_cond(1'b0);
    xbyte({dev, 1'b0}, 1'b1, q, a0);
    xbyte(ptr, 1'b1, q, a1);
    start_cond(1'b1);
    xbyte({dev, 1'b1}, 1'b1, q, a2);
    xbyte(8'hff, 1'b0, val[15:8], a3);
    xbyte(8'hff, 1'b1, val[7:0], a3);
    stop_cond();
    ok = !(a0 | a1 | a2);
  endtask

  // Coherent sample: upper word always before lower word
  task automatic rd_result(input logic [6:0] dev, input logic [1:0] ch,
                           output logic [27:0] v, output logic ok);
    logic [15:0] hi, lo;
    logic ok_hi, ok_lo;
    rd_reg(dev, 8'h00 + {5'h00, ch, 1'b0}, hi, ok_hi);
    rd_reg(dev, 8'h01 + {5'h00, ch, 1'b0}, lo, ok_lo);
    v = {hi[11:0], lo};
    ok = ok_hi & ok_lo;
  endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the status, interrupt and readback block
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import csrb_pkg::*;

  // Device address handed to the design, arbitrary
  localparam logic [6:0] DEV = 7'h2b;
  localparam logic [7:0] ST = CSRB_ADDR_STATUS;
  localparam logic [7:0] MSK = CSRB_ADDR_MASK;
  localparam logic [7:0] CFG = CSRB_ADDR_CONFIG;

  logic ref_clk;
  logic resetn;
  logic scl;
  logic sda_host;
  logic sda_out;
  logic sda_oe_n;
  logic shutdown_pin;
  logic irq_n_pin;
  logic conv_valid;
  logic conv_ready;
  csrb_conv_s conv_word;
  int error_cnt;
  int checks_done;
  // Open-drain data line: low when either side pulls
  wire sda_line = sda_host & (sda_oe_n | sda_out);

  csrb_top #(.DEV_ADDR(DEV)) csrb_top_inst (.ref_clk(ref_clk),
    .resetn(resetn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .shutdown_pin(shutdown_pin),
    .irq_n_pin(irq_n_pin), .conv_valid(conv_valid),
    .conv_word(conv_word), .conv_ready(conv_ready));

  csrb_host_model csrb_host_model_inst (.scl(scl), .sda_drv(sda_host),
    .sda_line(sda_line));

  // 40 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Distinct result pattern per index
  function automatic logic [27:0] dv(input int k);
    return 28'h9a5c3e1 + 28'(k) * 28'h0101013;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [7:0] ptr, input logic [15:0] exp);
    logic [15:0] v;
    logic ok;
    csrb_host_model_inst.rd_reg(DEV, ptr, v, ok);
    chk("read ack", 1, ok);
    chk($sformatf("register %h", ptr), exp, v);
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [15:0] val);
    logic ok;
    csrb_host_model_inst.wr_reg(DEV, ptr, val, ok);
    chk("write ack", 1, ok);
  endtask

  task automatic rd_res(input int ch, input logic [27:0] exp);
    logic [27:0] v;
    logic ok;
    csrb_host_model_inst.rd_result(DEV, 2'(ch), v, ok);
    chk("result ack", 1, ok);
    chk($sformatf("result %0d", ch), exp, v);
  endtask

  // One conversion word, held until the FIFO takes it
  task automatic push(input logic [1:0] ch, input logic lst,
                      input logic [5:0] err, input logic [27:0] d);
    @(posedge ref_clk);
    conv_valid <= 1'b1;
    conv_word <= {lst, ch, err, d};
    @(posedge ref_clk iff conv_ready === 1'b1);
    conv_valid <= 1'b0;
  endtask

  // Stay mode: level held all n cycles; else reached within n cycles
  task automatic irq_is(input logic exp, input int n, input logic stay);
    int k;
    k = 0;
    repeat (n)
    begin
      @(negedge ref_clk);
      if (irq_n_pin === exp)
        k++;
      if (!stay && k > 0)
        break;
    end
    chk("interrupt cycles", stay ? n : 1, k);
  endtask

  task automatic t_regs();
    logic ok;
    chk("interrupt after reset", 1, irq_n_pin);
    chk("ready after reset", 1, conv_ready);
    chk("data enable after reset", 1, sda_oe_n);
    rd(MSK, 16'h0000);
    rd(CFG, CSRB_CFG_RESET);
    wr(MSK, 16'h3f01);
    rd(MSK, 16'h3f01);
    wr(ST, 16'hffff);
    rd(ST, 16'h0000);
    rd(8'h1b, 16'h0000);
    csrb_host_model_inst.wr_reg(DEV ^ 7'h01, MSK, 16'h0000, ok);
    chk("foreign address ack", 0, ok);
    rd(MSK, 16'h3f01);
    $display("register test done");
  endtask

  task automatic t_group();
    wr(MSK, 16'h0001);
    wr(CFG, 16'h0000);
    for (int c = 0; c < 4; c++)
      push(2'(c), c == 3, 6'h00, dv(c));
    irq_is(1'b0, 40, 1'b0);
    rd(ST, 16'h0001);
    chk("interrupt after status read", 1, irq_n_pin);
    for (int c = 0; c < 4; c++)
      rd_res(c, dv(c));
    rd(ST, 16'h0000);
    $display("group test done");
  endtask

  // Host stays busy reading while words pile up behind it
  task automatic t_hold();
    int acc;
    logic r;
    logic full;
    acc = 0;
    full = 1'b0;
    push(2'd1, 1'b0, 6'h00, dv(9));
    rd(8'h03, 16'(dv(1)));
    fork
      rd(8'h1b, 16'h0000);
      begin
        #7700;
        @(posedge ref_clk);
        conv_valid <= 1'b1;
        conv_word <= {1'b0, 2'd0, 6'h00, dv(20)};
        repeat (16)
        begin
          @(negedge ref_clk);
          r = conv_ready;
          full = full | !r;
          @(posedge ref_clk);
          if (r)
          begin
            acc++;
            conv_word <= {1'b0, 2'd0, 6'h00, dv(20 + acc)};
          end
        end
        conv_valid <= 1'b0;
      end
    join
    // Eight stored words plus the one parked in the output stage
    chk("words taken", 9, acc);
    chk("full seen", 1, full);
    rd(ST, 16'h0002);
    rd(ST, 16'h0003);
    rd_res(0, dv(19 + acc));
    rd_res(1, dv(9));
    rd(ST, 16'h0000);
    $display("hold test done");
  endtask

  task automatic t_errors();
    push(2'd2, 1'b0, 6'h01, dv(2));
    irq_is(1'b1, 30, 1'b1);
    rd(ST, 16'h8104);
    rd(ST, 16'h0004);
    rd_res(2, dv(2));
    wr(MSK, 16'h2000);
    push(2'd3, 1'b0, 6'h20, dv(3));
    irq_is(1'b0, 40, 1'b0);
    push(2'd0, 1'b0, 6'h01, dv(0));
    rd(ST, 16'he008);
    chk("interrupt after error read", 1, irq_n_pin);
    $display("error test done");
  endtask

  task automatic t_sleep();
    wr(MSK, 16'h0001);
    wr(CFG, 16'h0080);
    push(2'd3, 1'b1, 6'h00, dv(5));
    irq_is(1'b1, 30, 1'b1);
    wr(CFG, 16'h2000);
    rd_res(3, 28'h0000000);
    wr(CFG, 16'h0000);
    push(2'd1, 1'b1, 6'h00, dv(6));
    irq_is(1'b0, 40, 1'b0);
    rd_res(1, dv(6));
    chk("interrupt after upper read", 1, irq_n_pin);
    push(2'd1, 1'b1, 6'h00, dv(7));
    irq_is(1'b0, 40, 1'b0);
    wr(CFG, 16'h2000);
    chk("interrupt after sleep", 1, irq_n_pin);
    wr(CFG, 16'h0000);
    push(2'd2, 1'b1, 6'h00, dv(8));
    irq_is(1'b0, 40, 1'b0);
    @(posedge ref_clk);
    shutdown_pin <= 1'b1;
    irq_is(1'b1, 10, 1'b0);
    @(posedge ref_clk);
    shutdown_pin <= 1'b0;
    rd_res(2, 28'h0000000);
    push(2'd0, 1'b1, 6'h00, dv(4));
    irq_is(1'b0, 40, 1'b0);
    wr(CSRB_ADDR_SWRST, 16'h8000);
    chk("interrupt after soft reset", 1, irq_n_pin);
    rd(MSK, 16'h0000);
    rd(CFG, CSRB_CFG_RESET);
    $display("sleep test done");
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence: 20-cycle reset, then each scenario in turn
  initial
  begin
    resetn = 1'b0;
    shutdown_pin = 1'b0;
    conv_valid = 1'b0;
    conv_word = '0;
    error_cnt = 0;
    checks_done = 0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_group();
    t_hold();
    t_errors();
    t_sleep();
    close_out();
  end

  // Watchdog: the run needs about 19000 cycles
  initial
  begin
    repeat (80000) @(posedge ref_clk);
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
